// [evt_bank_consts.vh]
// constants for the event enable and queued-event register bank
`ifndef EVT_BANK_CONSTS_VH
`define EVT_BANK_CONSTS_VH

`define NUM_CH          32
`define ADDR_W          6
`define RST_WORD        32'h0000_0000

`define OFF_EN_MASK     6'h00
`define OFF_EN_CLR      6'h04
`define OFF_EN_SET      6'h08
`define OFF_QUEUED      6'h0c
`define OFF_QUEUED_CLR  6'h10
`define OFF_DONE_MASK   6'h14
`define OFF_DONE_SET    6'h18
`define OFF_DONE_CLR    6'h1c
`define OFF_RAW_LATCH   6'h20
`define OFF_MANUAL      6'h24
`define OFF_DONE_STAT   6'h28
`define OFF_CHAIN       6'h2c

`endif

// [low_pick.v]
// lowest-numbered request picker for the event arbiter
`timescale 1ns/100ps
module low_pick (
    // requests
    input  wire [31:0] req_i,
    // choice
    output reg         found_o,
    output reg  [4:0]  index_o,
    output reg  [31:0] onehot_o
);
    integer k;

    always @* begin
        found_o  = 1'b0;
        index_o  = 5'h00;
        onehot_o = 32'h0000_0000;
        // scan downward so the lowest channel wins
        for (k = 31; k >= 0; k = k - 1) begin
            if (req_i[k]) begin
                found_o  = 1'b1;
                index_o  = k[4:0];
                onehot_o = 32'h0000_0001 << k;
            end
        end
    end
endmodule

// [evt_bank.v]
// event enable, queued-event and completion interrupt register bank
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "evt_bank_consts.vh"
module evt_bank (
    // clock and reset
    input  wire        CORE_CLK_I,
    input  wire        RST_I,
    // register port
    input  wire [5:0]  ADDR_I,
    input  wire [31:0] WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [31:0] RDATA_O,
    // event sources, one-cycle pulses per channel
    input  wire [31:0] EXT_EVT_I,
    input  wire [31:0] CHAIN_KICK_I,
    // transfer progress
    input  wire [31:0] XFER_RETIRE_I,
    input  wire [31:0] XFER_DONE_I,
    input  wire [31:0] DONE_IRQ_CFG_I,
    // queue submission
    output reg         QUEUE_VALID_O,
    output reg  [4:0]  QUEUE_CH_O,
    // interrupt
    output reg         IRQ_O
);

    // write hit on one register offset
    function wr_hit;
        input       wr;
        input [5:0] addr;
        input [5:0] off;
        begin
            wr_hit = wr && (addr == off);
        end
    endfunction

    reg  [31:0] evt_enable_mask_q;
    reg  [31:0] evt_enable_mask_d;
    reg  [31:0] queued_evt_flags_q;
    reg  [31:0] queued_evt_flags_d;
    reg  [31:0] done_irq_mask_q;
    reg  [31:0] done_irq_mask_d;
    reg  [31:0] raw_evt_latch_q;
    reg  [31:0] raw_evt_latch_d;
    reg  [31:0] manual_kick_flags_q;
    reg  [31:0] manual_kick_flags_d;
    reg  [31:0] chain_kick_flags_q;
    reg  [31:0] chain_kick_flags_d;
    reg  [31:0] done_status_q;
    reg  [31:0] done_status_d;
    reg  [31:0] rdata_d;

    wire        en_set_wr;
    wire        en_clr_wr;
    wire        queued_clr_wr;
    wire        done_set_wr;
    wire        done_clr_wr;
    wire        manual_wr;
    wire        stat_clr_wr;
    wire [31:0] ext_ready;
    wire [31:0] candidates;
    wire        pick_found;
    wire [4:0]  pick_index;
    wire [31:0] pick_onehot;
    wire [31:0] done_events;

    assign en_set_wr     = wr_hit(WR_I, ADDR_I, `OFF_EN_SET);
    assign en_clr_wr     = wr_hit(WR_I, ADDR_I, `OFF_EN_CLR);
    assign queued_clr_wr = wr_hit(WR_I, ADDR_I, `OFF_QUEUED_CLR);
    assign done_set_wr   = wr_hit(WR_I, ADDR_I, `OFF_DONE_SET);
    assign done_clr_wr   = wr_hit(WR_I, ADDR_I, `OFF_DONE_CLR);
    assign manual_wr     = wr_hit(WR_I, ADDR_I, `OFF_MANUAL);
    assign stat_clr_wr   = wr_hit(WR_I, ADDR_I, `OFF_DONE_STAT);

    // only latched external events are gated by the enable mask
    assign ext_ready  = raw_evt_latch_q & evt_enable_mask_q;
    // chained and manual kicks bypass the enable mask
    assign candidates = (ext_ready | chain_kick_flags_q |
                         manual_kick_flags_q) &
                        ~queued_evt_flags_q;

    low_pick u_pick (
        .req_i    (candidates),
        .found_o  (pick_found),
        .index_o  (pick_index),
        .onehot_o (pick_onehot)
    );

    // completion only counts where the setup table asked for it
    assign done_events = XFER_DONE_I & DONE_IRQ_CFG_I;

    // event enable mask: no direct write path exists
    always @* begin
        evt_enable_mask_d = evt_enable_mask_q;
        if (en_clr_wr) begin
            evt_enable_mask_d = evt_enable_mask_d & ~WDATA_I;
        end
        if (en_set_wr) begin
            evt_enable_mask_d = evt_enable_mask_d | WDATA_I;
        end
    end

    // raw latch captures every event whatever the mask holds
    always @* begin
        raw_evt_latch_d = raw_evt_latch_q;
        if (pick_found) begin
            raw_evt_latch_d = raw_evt_latch_d & ~pick_onehot;
        end
        // a fresh event outranks the service clear
        raw_evt_latch_d = raw_evt_latch_d | EXT_EVT_I;
    end

    // manual kicks, written ones set, cleared when serviced
    always @* begin
        manual_kick_flags_d = manual_kick_flags_q;
        if (pick_found) begin
            manual_kick_flags_d = manual_kick_flags_d & ~pick_onehot;
        end
        if (manual_wr) begin
            manual_kick_flags_d = manual_kick_flags_d | WDATA_I;
        end
    end

    // chained kicks, cleared when serviced, new kick wins
    always @* begin
        chain_kick_flags_d = chain_kick_flags_q;
        if (pick_found) begin
            chain_kick_flags_d = chain_kick_flags_d & ~pick_onehot;
        end
        chain_kick_flags_d = chain_kick_flags_d | CHAIN_KICK_I;
    end

    // queued flags: retire or software clears, then the set lands
    always @* begin
        queued_evt_flags_d = queued_evt_flags_q;
        queued_evt_flags_d = queued_evt_flags_d &
                             ~XFER_RETIRE_I;
        if (queued_clr_wr) begin
            queued_evt_flags_d = queued_evt_flags_d &
                                 ~WDATA_I;
        end
        if (pick_found) begin
            // set applied last so a same-cycle clear loses
            queued_evt_flags_d = queued_evt_flags_d |
                                 pick_onehot;
        end
    end

    // completion interrupt mask, set and clear ports only
    always @* begin
        done_irq_mask_d = done_irq_mask_q;
        if (done_clr_wr) begin
            done_irq_mask_d = done_irq_mask_d & ~WDATA_I;
        end
        if (done_set_wr) begin
            done_irq_mask_d = done_irq_mask_d | WDATA_I;
        end
    end

    // sticky completion status, write one clears, event wins
    always @* begin
        done_status_d = done_status_q;
        if (stat_clr_wr) begin
            done_status_d = done_status_d & ~WDATA_I;
        end
        done_status_d = done_status_d | done_events;
    end

    // read mux; write-only ports and holes read as zero
    always @* begin
        rdata_d = `RST_WORD;
        if (RD_I) begin
            if (ADDR_I == `OFF_EN_MASK) begin
                rdata_d = evt_enable_mask_q;
            end else if (ADDR_I == `OFF_QUEUED) begin
                rdata_d = queued_evt_flags_q;
            end else if (ADDR_I == `OFF_DONE_MASK) begin
                rdata_d = done_irq_mask_q;
            end else if (ADDR_I == `OFF_RAW_LATCH) begin
                rdata_d = raw_evt_latch_q;
            end else if (ADDR_I == `OFF_MANUAL) begin
                rdata_d = manual_kick_flags_q;
            end else if (ADDR_I == `OFF_DONE_STAT) begin
                rdata_d = done_status_q;
            end else if (ADDR_I == `OFF_CHAIN) begin
                rdata_d = chain_kick_flags_q;
            end else begin
                rdata_d = `RST_WORD;
            end
        end
    end

    // state registers
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            evt_enable_mask_q   <= `RST_WORD;
            queued_evt_flags_q  <= `RST_WORD;
            done_irq_mask_q     <= `RST_WORD;
            raw_evt_latch_q     <= `RST_WORD;
            manual_kick_flags_q <= `RST_WORD;
            chain_kick_flags_q  <= `RST_WORD;
            done_status_q       <= `RST_WORD;
        end else begin
            evt_enable_mask_q   <= evt_enable_mask_d;
            queued_evt_flags_q  <= queued_evt_flags_d;
            done_irq_mask_q     <= done_irq_mask_d;
            raw_evt_latch_q     <= raw_evt_latch_d;
            manual_kick_flags_q <= manual_kick_flags_d;
            chain_kick_flags_q  <= chain_kick_flags_d;
            done_status_q       <= done_status_d;
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= `RST_WORD;
        end else begin
            RDATA_O <= rdata_d;
        end
    end

    // one submission per cycle; the queue never stalls this bank
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            QUEUE_VALID_O <= 1'b0;
            QUEUE_CH_O    <= 5'h00;
        end else begin
            QUEUE_VALID_O <= pick_found;
            QUEUE_CH_O    <= pick_index;
        end
    end

    // interrupt follows the updated status so a clear drops it at once
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(done_status_d & done_irq_mask_d);
        end
    end

endmodule

// [evt_bank_chk.sv]
// assertion checker for the event enable and queued-event bank
`timescale 1ns/100ps
module evt_bank_chk (
    // clock, reset and register port
    input wire        CORE_CLK_I,
    input wire        RST_I,
    input wire [5:0]  ADDR_I,
    input wire [31:0] WDATA_I,
    input wire        WR_I,
    input wire        RD_I,
    input wire [31:0] RDATA_O,
    // transfer progress
    input wire [31:0] XFER_RETIRE_I,
    input wire [31:0] XFER_DONE_I,
    input wire [31:0] DONE_IRQ_CFG_I,
    // outputs
    input wire        QUEUE_VALID_O,
    input wire [4:0]  QUEUE_CH_O,
    input wire        IRQ_O
);
    reg  [31:0] en_q, dm_q, st_q, qf_q;
    wire [31:0] pick = QUEUE_VALID_O ? 32'h1 << QUEUE_CH_O : 32'h0;
    wire [31:0] qf_now = qf_q | pick;
    wire        dn_hit = |(XFER_DONE_I & DONE_IRQ_CFG_I);
    wire        m_set = WR_I && ADDR_I == 6'h18;
    function [31:0] wm(input [5:0] a);
        wm = (WR_I && ADDR_I == a) ? WDATA_I : 32'h0;
    endfunction
    // queued shadow lags by the pick in flight, so reads use qf_now
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            en_q <= 32'h0;
            dm_q <= 32'h0;
            st_q <= 32'h0;
            qf_q <= 32'h0;
        end else begin
            en_q <= (en_q | wm(6'h08)) & ~wm(6'h04);
            dm_q <= (dm_q | wm(6'h18)) & ~wm(6'h1c);
            st_q <= (st_q & ~wm(6'h28)) | (XFER_DONE_I & DONE_IRQ_CFG_I);
            qf_q <= (qf_q | pick) & ~(XFER_RETIRE_I | wm(6'h10));
        end
    end
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    en_read_a:
        assert property (RD_I && ADDR_I == 6'h00 |=> RDATA_O == $past(en_q))
        else $error("enable mask read differs");
    mask_read_a:
        assert property (RD_I && ADDR_I == 6'h14 |=> RDATA_O == $past(dm_q))
        else $error("done mask read differs");
    queued_read_a:
        assert property (RD_I && ADDR_I == 6'h0c |=> RDATA_O == $past(qf_now))
        else $error("queued flags read differs");
    no_requeue_a:
        assert property (QUEUE_VALID_O |-> !qf_q[QUEUE_CH_O])
        else $error("queued channel picked again");
    irq_level_a:
        assert property (IRQ_O == |(st_q & dm_q))
        else $error("interrupt level differs");
    irq_cause_a:
        assert property ($rose(IRQ_O) |-> $past(dn_hit) || $past(m_set))
        else $error("interrupt rose without cause");
    wo_read_a:
        assert property (RD_I && ADDR_I inside {6'h04, 6'h08, 6'h10, 6'h18,
            6'h1c} |=> RDATA_O == 32'h0)
        else $error("write-only port read nonzero");
    reset_quiet_a:
        assert property ($fell(RST_I) |-> RDATA_O == 32'h0 && !IRQ_O
            && !QUEUE_VALID_O)
        else $error("outputs busy after reset");
    cover property (QUEUE_VALID_O);
    cover property ($rose(IRQ_O));
    cover property (RD_I && ADDR_I == 6'h0c ##1 RDATA_O != 32'h0);
endmodule
bind evt_bank evt_bank_chk evt_bank_chk_inst (
    .CORE_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .XFER_RETIRE_I, .XFER_DONE_I, .DONE_IRQ_CFG_I,
    .QUEUE_VALID_O, .QUEUE_CH_O, .IRQ_O
);

// [tb_evt_bank.sv]
// self-checking testbench for the event enable and queued-event bank
`timescale 1ns/100ps
module tb_evt_bank;
    reg          CORE_CLK_I = 1'b0;
    reg          RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0, rd_p = 1'b0;
    reg  [5:0]   ADDR_I = 6'h0;
    reg  [31:0]  WDATA_I = 32'h0, EXT_EVT_I = 32'h0, CHAIN_KICK_I = 32'h0;
    reg  [31:0]  XFER_RETIRE_I = 32'h0, XFER_DONE_I = 32'h0, e, v;
    reg  [31:0]  DONE_IRQ_CFG_I = 32'h0, m[2] = '{32'h0, 32'h0};
    wire [31:0]  RDATA_O;
    wire [4:0]   QUEUE_CH_O;
    wire         QUEUE_VALID_O, IRQ_O;
    integer      n_fail = 0, tests_run = 0, seed = 32'h15647300, k, i;
    logic [31:0] exp_rd[$], exp_ch[$];
    evt_bank evt_bank_inst (.CORE_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I,
        .RD_I, .RDATA_O, .EXT_EVT_I, .CHAIN_KICK_I, .XFER_RETIRE_I,
        .XFER_DONE_I, .DONE_IRQ_CFG_I, .QUEUE_VALID_O, .QUEUE_CH_O, .IRQ_O);
    always #25 CORE_CLK_I = ~CORE_CLK_I;
    task chk(input [31:0] s, input [31:0] x);
        tests_run++;
        if (s !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task print_verdict;
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // strobes stay up until the next call, so back-to-back cycles work
    task bus(input w, input r, input [5:0] a, input [31:0] d);
        WR_I <= w;
        RD_I <= r;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CORE_CLK_I);
    endtask
    task rd(input [5:0] a, input [31:0] x);
        exp_rd.push_back(x);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task idle(input integer n);
        repeat (n) bus(1'b0, 1'b0, 6'h0, 32'h0);
    endtask
    task lvl(input b);
        @(negedge CORE_CLK_I);
        chk({31'h0, IRQ_O}, {31'h0, b});
        @(posedge CORE_CLK_I);
    endtask
    // an unexpected pick or read finds an empty queue and fails
    always @(posedge CORE_CLK_I) begin
        if (rd_p) begin
            e = exp_rd.size() ? exp_rd.pop_front() : 32'hx;
            chk(RDATA_O, e);
        end
        if (QUEUE_VALID_O) begin
            e = exp_ch.size() ? exp_ch.pop_front() : 32'hx;
            chk({27'h0, QUEUE_CH_O}, e);
        end
        rd_p <= RD_I;
    end
    initial begin
        repeat (5000) @(posedge CORE_CLK_I);
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge CORE_CLK_I);
        RST_I <= 1'b0;
        idle(1);
        for (k = 0; k < 13; k++)
            rd(6'(k * 4), 32'h0);
        for (i = 0; i < 8; i++) begin
            k = i % 2;
            v = $random(seed);
            bus(1'b1, 1'b0, k ? 6'h18 : 6'h08, v);
            m[k] = m[k] | v;
            rd(k ? 6'h14 : 6'h00, m[k]);
            v = $random(seed);
            bus(1'b1, 1'b0, k ? 6'h1c : 6'h04, v);
            m[k] = m[k] & ~v;
            bus(1'b1, 1'b0, k ? 6'h14 : 6'h00, ~m[k]);
            rd(k ? 6'h14 : 6'h00, m[k]);
            rd(k ? 6'h18 : 6'h08, 32'h0);
        end
        bus(1'b1, 1'b0, 6'h04, 32'hffffffff);
        EXT_EVT_I <= 32'h8;
        idle(1);
        EXT_EVT_I <= 32'h0;
        idle(4);
        exp_ch.push_back(3);
        bus(1'b1, 1'b0, 6'h08, 32'h8);
        exp_ch.push_back(7);
        CHAIN_KICK_I <= 32'h80;
        idle(1);
        CHAIN_KICK_I <= 32'h0;
        exp_ch.push_back(9);
        bus(1'b1, 1'b0, 6'h24, 32'h200);
        idle(4);
        rd(6'h0c, 32'h288);
        CHAIN_KICK_I <= 32'h80;
        idle(1);
        CHAIN_KICK_I <= 32'h0;
        idle(4);
        exp_ch.push_back(7);
        bus(1'b1, 1'b0, 6'h10, 32'h8);
        XFER_RETIRE_I <= 32'h80;
        idle(1);
        XFER_RETIRE_I <= 32'h0;
        idle(4);
        rd(6'h0c, 32'h280);
        exp_ch.push_back(3);
        EXT_EVT_I <= 32'h8;
        idle(1);
        EXT_EVT_I <= 32'h0;
        bus(1'b1, 1'b0, 6'h10, 32'h8);
        idle(3);
        rd(6'h0c, 32'h288);
        bus(1'b1, 1'b0, 6'h1c, 32'hffffffff);
        bus(1'b1, 1'b0, 6'h18, 32'h20);
        DONE_IRQ_CFG_I <= 32'h20;
        XFER_DONE_I <= 32'h60;
        idle(1);
        XFER_DONE_I <= 32'h0;
        rd(6'h28, 32'h20);
        idle(1);
        lvl(1'b1);
        bus(1'b1, 1'b0, 6'h1c, 32'h20);
        idle(1);
        lvl(1'b0);
        bus(1'b1, 1'b0, 6'h18, 32'h20);
        bus(1'b1, 1'b0, 6'h28, 32'h20);
        idle(1);
        lvl(1'b0);
        rd(6'h28, 32'h0);
        idle(4);
        chk(32'(exp_ch.size()), 32'h0);
        chk(32'(exp_rd.size()), 32'h0);
        print_verdict;
    end
endmodule
